/* core/ptic_defines.svh */
// constants of the pen-touch interrupt control block
// assumes it is included by bare name from core/ sources
`ifndef PTIC_DEFINES_SVH
`define PTIC_DEFINES_SVH

// serial frame positions, counted in serial clock edges from the start bit
`define PTIC_CNT_W 5
`define PTIC_EDGE_START 5'h01
`define PTIC_EDGE_CHAN 5'h04
`define PTIC_EDGE_REF 5'h07
`define PTIC_EDGE_CMD 5'h08
`define PTIC_FALL_WIN_BEGIN 5'h05
`define PTIC_FALL_WIN_END 5'h14
`define PTIC_FRAME_EDGES 5'h18

// control word layout: start, channel[2:0], mode, ser, ref power, adc power
`define PTIC_CTL_W 8
`define PTIC_CHAN_W 3
`define PTIC_BIT_ADC_PWR 0
`define PTIC_BIT_REF_PWR 1
`define PTIC_CHAN_LSB 4
`define PTIC_CHAN_MSB 6

// full power-down value and the value held before the first command
`define PTIC_CTL_CLEAR 8'h00
`define PTIC_CTL_POWERUP 8'h03

// channels that drive the plates (x, y and both pressure channels)
`define PTIC_PLATE_CHAN_MASK 8'h3a

`endif

/* core/ptic_link.sv */
// serial-clock side: command capture and frame edge tracking
// assumes chip select and data in change away from rising serial clock edges
`include "ptic_defines.svh"
`default_nettype none

module ptic_link
    import ptic_pkg::*;
(
    input wire logic i_serial_clock,
    input wire logic i_rst,
    input wire logic i_chip_select_n,
    input wire logic i_din,
    output logic o_win,
    output logic o_post,
    output logic [`PTIC_CHAN_W-1:0] o_cur_chan,
    output logic o_ref_tgl,
    output logic o_ref_bit,
    output logic o_cmd_tgl,
    output logic [`PTIC_CTL_W-1:0] o_cmd_word
);

    logic rst_s1_q;
    logic rst_q;
    logic [`PTIC_CNT_W-1:0] cnt_q;
    logic [`PTIC_CTL_W-1:0] shift_q;
    logic [`PTIC_CNT_W-1:0] edge_nr;

    always_ff @(posedge i_serial_clock) begin
        rst_s1_q <= i_rst;
        rst_q <= rst_s1_q;
    end

    assign edge_nr = cnt_q + `PTIC_EDGE_START;

    // frame starts at the first high bit after chip select falls
    always_ff @(posedge i_serial_clock) begin
        if (rst_q || i_chip_select_n) begin
            cnt_q <= '0;
        end else if (cnt_q == '0 || cnt_q == `PTIC_FRAME_EDGES) begin
            cnt_q <= i_din ? `PTIC_EDGE_START : '0;
        end else begin
            cnt_q <= edge_nr;
        end
    end

    always_ff @(posedge i_serial_clock) begin
        if (rst_q) begin
            shift_q <= '0;
        end else begin
            shift_q <= {shift_q[`PTIC_CTL_W-2:0], i_din};
        end
    end

    // capture channel, reference bit and whole command at their edges
    always_ff @(posedge i_serial_clock) begin
        if (rst_q) begin
            o_cur_chan <= '0;
            o_ref_tgl <= 1'b0;
            o_ref_bit <= 1'b0;
            o_cmd_tgl <= 1'b0;
            o_cmd_word <= '0;
        end else if (!i_chip_select_n && cnt_q != '0 && cnt_q != `PTIC_FRAME_EDGES) begin
            if (edge_nr == `PTIC_EDGE_CHAN) begin
                o_cur_chan <= {shift_q[1:0], i_din};
            end
            if (edge_nr == `PTIC_EDGE_REF) begin
                o_ref_bit <= i_din;
                o_ref_tgl <= ~o_ref_tgl;
            end
            if (edge_nr == `PTIC_EDGE_CMD) begin
                o_cmd_word <= {shift_q[`PTIC_CTL_W-2:0], i_din};
                o_cmd_tgl <= ~o_cmd_tgl;
            end
        end
    end

    // falling edges mark the forced window and the tail of the frame
    always_ff @(negedge i_serial_clock) begin
        if (rst_q) begin
            o_win <= 1'b0;
            o_post <= 1'b0;
        end else if (cnt_q == `PTIC_EDGE_START) begin
            o_win <= 1'b0;
            o_post <= 1'b0;
        end else if (cnt_q == `PTIC_FALL_WIN_BEGIN) begin
            o_win <= 1'b1;
        end else if (cnt_q == `PTIC_FALL_WIN_END) begin
            o_win <= 1'b0;
            o_post <= 1'b1;
        end
    end

endmodule

`default_nettype wire

/* core/ptic_pkg.sv */
// types and shared decoding of the pen-touch interrupt control block
// assumes ptic_defines.svh is reachable on the include path
`include "ptic_defines.svh"
`default_nettype none

package ptic_pkg;

    // where the sys-domain view stands inside a chip-select frame
    typedef enum logic [1:0] {
        PTIC_PH_IDLE,
        PTIC_PH_PRE,
        PTIC_PH_WIN,
        PTIC_PH_POST
    } ptic_phase_t;

    typedef logic [`PTIC_CHAN_W-1:0] ptic_chan_t;

    // true for a channel that connects the touch plates
    function automatic logic ptic_is_plate(input ptic_chan_t chan);
        logic [7:0] mask;
        mask = `PTIC_PLATE_CHAN_MASK;
        return mask[chan];
    endfunction

endpackage

`default_nettype wire

/* core/ptic_sync3.sv */
// three-stage synchroniser with agreement filter
// assumes a slowly changing input from another clock domain
`default_nettype none

module ptic_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit changes once the second and third stage agree
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sync <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    o_sync[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

/* core/ptic_top.sv */
// pen-touch interrupt control of a four-wire resistive touch controller
// assumes a host drives chip select, serial clock and data in; plate contact
// arrives as a digital level from the analog front end
`include "ptic_defines.svh"
`default_nettype none

// Operation
// - in power-down, ground y-minus and enable x-plus pull-up for detection
// - chip select high: interrupt follows touch unless both power bits set
// - adc power bit updates at eighth rising serial clock; old value rules before
// - reference power follows only the reference power bit
// - falls five to twenty: plate channel forces interrupt low
// - falls five to twenty: other channels force interrupt high
// - before fifth clock, stored adc bit zero: interrupt follows touch
// - before fifth clock, stored adc bit one: low for plate, else high
// - after twentieth fall, current adc bit zero: interrupt follows touch
// - after twentieth fall, current adc bit one: low for plate, else high
// - chip select and data in high: clear control, float plates, interrupt high
// - before first command control state is undefined; held as both bits set
// - control state holds the most recent command until replaced
// - reference power bit takes effect at seventh rising serial clock
// - command sampled on rising clocks, starting at first high bit
module ptic_top
    import ptic_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_SERIAL_CLOCK,
    input wire logic I_CHIP_SELECT_N,
    input wire logic I_DIN,
    input wire logic I_TOUCH_DETECT,
    output logic O_TOUCH_IRQ_N,
    output logic O_Y_MINUS_PLATE_GND_EN,
    output logic O_INTERNAL_PULLUP_EN,
    output logic O_PLATE_DRIVE_EN,
    output logic O_REF_POWER,
    output logic O_ADC_POWER,
    output logic O_FULL_POWER_DOWN,
    output logic O_CONFIGURED,
    output logic [`PTIC_CTL_W-1:0] O_CTL_REG
);

    // ****************************************************************
    // link side
    // ****************************************************************

    logic lk_win;
    logic lk_post;
    logic [`PTIC_CHAN_W-1:0] lk_cur_chan;
    logic lk_ref_tgl;
    logic lk_ref_bit;
    logic lk_cmd_tgl;
    logic [`PTIC_CTL_W-1:0] lk_cmd_word;

    ptic_link u_link (
        .i_serial_clock(I_SERIAL_CLOCK),
        .i_rst(I_RST),
        .i_chip_select_n(I_CHIP_SELECT_N),
        .i_din(I_DIN),
        .o_win(lk_win),
        .o_post(lk_post),
        .o_cur_chan(lk_cur_chan),
        .o_ref_tgl(lk_ref_tgl),
        .o_ref_bit(lk_ref_bit),
        .o_cmd_tgl(lk_cmd_tgl),
        .o_cmd_word(lk_cmd_word)
    );

    // ****************************************************************
    // crossing into the system clock
    // ****************************************************************

    localparam int SYNC_W = 3 + `PTIC_CHAN_W + 3 + 1 + `PTIC_CTL_W + 1;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic cs_act_s;
    logic cs_n_s;
    logic din_s;
    logic touch_s;
    logic win_s;
    logic post_s;
    logic [`PTIC_CHAN_W-1:0] cur_chan_s;
    logic ref_tgl_s;
    logic ref_bit_s;
    logic cmd_tgl_s;
    logic [`PTIC_CTL_W-1:0] cmd_word_s;

    // select crosses as active high so the synchroniser's reset value reads idle
    assign sync_in = {!I_CHIP_SELECT_N, I_DIN, I_TOUCH_DETECT, lk_win, lk_post, lk_cur_chan,
                      lk_ref_tgl, lk_ref_bit, lk_cmd_tgl, lk_cmd_word};

    ptic_sync3 #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_async(sync_in),
        .o_sync(sync_out)
    );

    assign {cs_act_s, din_s, touch_s, win_s, post_s, cur_chan_s,
            ref_tgl_s, ref_bit_s, cmd_tgl_s, cmd_word_s} = sync_out;
    assign cs_n_s = !cs_act_s;

    // ****************************************************************
    // event detection
    // ****************************************************************

    logic cs_n_q;
    logic win_q;
    logic post_q;
    logic ref_tgl_q;
    logic cmd_tgl_q;
    logic cs_fall;
    logic win_rise;
    logic post_rise;
    logic ref_evt;
    logic cmd_evt;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            cs_n_q <= 1'b1;
            win_q <= 1'b0;
            post_q <= 1'b0;
            ref_tgl_q <= 1'b0;
            cmd_tgl_q <= 1'b0;
        end else begin
            cs_n_q <= cs_n_s;
            win_q <= win_s;
            post_q <= post_s;
            ref_tgl_q <= ref_tgl_s;
            cmd_tgl_q <= cmd_tgl_s;
        end
    end

    assign cs_fall = cs_n_q && !cs_n_s;
    assign win_rise = win_s && !win_q;
    assign post_rise = post_s && !post_q;
    assign ref_evt = ref_tgl_s != ref_tgl_q;
    assign cmd_evt = cmd_tgl_s != cmd_tgl_q;

    // ****************************************************************
    // frame phase
    // ****************************************************************

    ptic_phase_t phase_q;
    ptic_phase_t phase_d;

    // phase from counted serial clock edges
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            PTIC_PH_IDLE: begin
                if (cs_fall) begin
                    phase_d = PTIC_PH_PRE;
                end
            end
            PTIC_PH_PRE: begin
                if (win_rise) begin
                    phase_d = PTIC_PH_WIN;
                end
            end
            PTIC_PH_WIN: begin
                if (post_rise) begin
                    phase_d = PTIC_PH_POST;
                end
            end
            PTIC_PH_POST: begin
                if (win_rise) begin
                    phase_d = PTIC_PH_WIN;
                end
            end
        endcase
        if (cs_n_s) begin
            phase_d = PTIC_PH_IDLE;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            phase_q <= PTIC_PH_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ****************************************************************
    // control register
    // ****************************************************************

    logic [`PTIC_CTL_W-1:0] ctl_q;
    logic full_pd;
    logic configured_q;

    // chip select and data in both high
    assign full_pd = cs_n_s && din_s;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            ctl_q <= `PTIC_CTL_POWERUP;
        end else if (full_pd) begin
            ctl_q <= `PTIC_CTL_CLEAR;
        end else begin
            if (cmd_evt) begin
                ctl_q <= cmd_word_s;
            end else if (ref_evt) begin
                ctl_q[`PTIC_BIT_REF_PWR] <= ref_bit_s;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            configured_q <= 1'b0;
        end else if (cmd_evt || full_pd) begin
            configured_q <= 1'b1;
        end
    end

    logic adc_pwr;
    logic ref_pwr;
    ptic_chan_t ctl_chan;

    assign adc_pwr = ctl_q[`PTIC_BIT_ADC_PWR];
    assign ref_pwr = ctl_q[`PTIC_BIT_REF_PWR];
    assign ctl_chan = ctl_q[`PTIC_CHAN_MSB:`PTIC_CHAN_LSB];

    // ****************************************************************
    // interrupt level
    // ****************************************************************

    logic irq_n_d;
    logic touch_en_d;

    always_comb begin
        irq_n_d = 1'b1;
        touch_en_d = 1'b0;
        unique case (phase_q)
            PTIC_PH_IDLE: begin
                if (full_pd) begin
                    irq_n_d = 1'b1;
                end else if (adc_pwr && ref_pwr) begin
                    irq_n_d = 1'b1;
                end else begin
                    irq_n_d = !touch_s;
                    touch_en_d = 1'b1;
                end
            end
            PTIC_PH_WIN: begin
                irq_n_d = !ptic_is_plate(cur_chan_s);
            end
            PTIC_PH_PRE, PTIC_PH_POST: begin
                if (adc_pwr) begin
                    irq_n_d = !ptic_is_plate(ctl_chan);
                end else begin
                    irq_n_d = !touch_s;
                    touch_en_d = 1'b1;
                end
            end
        endcase
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_TOUCH_IRQ_N <= 1'b1;
        end else begin
            O_TOUCH_IRQ_N <= irq_n_d;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_Y_MINUS_PLATE_GND_EN <= 1'b0;
            O_INTERNAL_PULLUP_EN <= 1'b0;
        end else begin
            O_Y_MINUS_PLATE_GND_EN <= touch_en_d;
            O_INTERNAL_PULLUP_EN <= touch_en_d;
        end
    end

    // plates driven during a plate conversion or, inside a frame, for a stored plate channel while adc power is kept
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_PLATE_DRIVE_EN <= 1'b0;
        end else if (phase_q == PTIC_PH_WIN) begin
            O_PLATE_DRIVE_EN <= ptic_is_plate(cur_chan_s);
        end else if (phase_q == PTIC_PH_IDLE) begin
            O_PLATE_DRIVE_EN <= 1'b0;
        end else begin
            O_PLATE_DRIVE_EN <= adc_pwr && ptic_is_plate(ctl_chan);
        end
    end

    // reference from its own bit only
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_REF_POWER <= 1'b0;
        end else begin
            O_REF_POWER <= ref_pwr;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_ADC_POWER <= 1'b0;
        end else begin
            O_ADC_POWER <= (phase_q != PTIC_PH_IDLE) && (adc_pwr || phase_q == PTIC_PH_WIN);
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_FULL_POWER_DOWN <= 1'b0;
            O_CONFIGURED <= 1'b0;
            O_CTL_REG <= '0;
        end else begin
            O_FULL_POWER_DOWN <= full_pd;
            O_CONFIGURED <= configured_q;
            O_CTL_REG <= ctl_q;
        end
    end

endmodule

`default_nettype wire

/* verification/ptic_chk.sv */
// checker of the pen-touch interrupt control top ports
// assumes a bind to ptic_top from the bench top file
`include "ptic_defines.svh"
`default_nettype none

module ptic_chk (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_SERIAL_CLOCK,
    input wire logic I_CHIP_SELECT_N,
    input wire logic I_DIN,
    input wire logic I_TOUCH_DETECT,
    input wire logic O_TOUCH_IRQ_N,
    input wire logic O_Y_MINUS_PLATE_GND_EN,
    input wire logic O_INTERNAL_PULLUP_EN,
    input wire logic O_PLATE_DRIVE_EN,
    input wire logic O_REF_POWER,
    input wire logic O_ADC_POWER,
    input wire logic O_FULL_POWER_DOWN,
    input wire logic O_CONFIGURED,
    input wire logic [`PTIC_CTL_W-1:0] O_CTL_REG
);
    // ************************
    // system clock properties
    // ************************
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);

    a_gnd_pullup_pair: assert property (O_Y_MINUS_PLATE_GND_EN == O_INTERNAL_PULLUP_EN)
        else $error("ground and pull-up enables differ");
    a_ref_bit_only: assert property ($stable(O_CTL_REG[1]) [*3] |-> O_REF_POWER == O_CTL_REG[1])
        else $error("reference power differs from its bit");
    a_full_pd_seen: assert property ((I_CHIP_SELECT_N && I_DIN) [*8] |-> O_FULL_POWER_DOWN)
        else $error("full power-down not detected");
    a_full_pd_clear: assert property (O_FULL_POWER_DOWN [*3] |->
        O_CTL_REG == 8'h00 && O_TOUCH_IRQ_N && !O_PLATE_DRIVE_EN)
        else $error("full power-down state wrong");
    a_cfg_sticky: assert property (O_CONFIGURED |=> O_CONFIGURED)
        else $error("configured flag dropped");
    a_reset_standin: assert property ($fell(I_RST) |-> ##[1:2] O_CTL_REG == 8'h03 && O_REF_POWER)
        else $error("stand-in control value missing");
    a_ctl_holds: assert property (I_CHIP_SELECT_N [*8] ##0 !O_FULL_POWER_DOWN && !$past(I_RST)
        |-> $stable(O_CTL_REG))
        else $error("control changed outside a command");
    a_idle_follows: assert property ((I_CHIP_SELECT_N && !O_FULL_POWER_DOWN && O_CTL_REG[1:0] != 2'h3
        && $stable(I_TOUCH_DETECT)) [*8] |-> O_TOUCH_IRQ_N == !I_TOUCH_DETECT)
        else $error("idle interrupt does not follow touch");
    a_idle_disabled: assert property ((I_CHIP_SELECT_N && O_CTL_REG[1:0] == 2'h3) [*8] |-> O_TOUCH_IRQ_N)
        else $error("interrupt not held high");
    a_idle_drivers_off: assert property (I_CHIP_SELECT_N [*8] |-> !O_PLATE_DRIVE_EN && !O_ADC_POWER)
        else $error("drivers or adc on while deselected");
    a_cfg_after_pd: assert property (O_FULL_POWER_DOWN |=> O_CONFIGURED)
        else $error("configured flag not set by full power-down");
endmodule

`default_nettype wire

/* verification/ptic_host.sv */
// host model driving the serial link of the touch controller
// assumes the bench calls its tasks one at a time
`default_nettype none

module ptic_host (
    output logic o_serial_clock,
    output logic o_chip_select_n,
    output logic o_din
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************
    // link driver
    // ************
    localparam int HALF = 6;
    logic [31:0] sh;
    initial begin
        o_serial_clock = 1'b0;
        o_chip_select_n = 1'b1;
        o_din = 1'b0;
        sh = 32'h0;
    end
    task automatic start(input logic [31:0] w);
        sh = w;
        o_chip_select_n = 1'b0;
        #(HALF);
    endtask
    task automatic pulses(input int n, input int gap);
        for (int k = 0; k < n; k++) begin
            o_din = sh[31];
            sh = sh << 1;
            #(HALF) o_serial_clock = 1'b1;
            #(HALF) o_serial_clock = 1'b0;
            #(gap);
        end
    endtask
    task automatic stop();
        #(HALF) o_chip_select_n = 1'b1;
        o_din = 1'b0;
    endtask
    task automatic hold_din(input logic v);
        o_din = v;
    endtask
endmodule

`default_nettype wire

/* verification/ptic_top_bench.sv */
// self-checking bench of the pen-touch interrupt control block
// assumes ptic_host drives the link and ptic_chk is bound to the top
`include "ptic_defines.svh"
`default_nettype none

module ptic_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ***************
    // bench and test
    // ***************
    localparam logic [7:0] MASK = `PTIC_PLATE_CHAN_MASK;
    logic clk, rst, sclk, cs_n, din, touch;
    logic irq_n, gnd_en, pu_en, drv_en, ref_pw, adc_pw, fpd, cfg;
    logic [7:0] ctl, st;
    logic [9:0] expq[$];
    string names[4] = '{"irq", "ctl", "ref", "gnd"};
    int failures = 0, num_checks = 0, seed = 34995, cycles = 0, r;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ptic_host host (.o_serial_clock(sclk), .o_chip_select_n(cs_n), .o_din(din));
    ptic_top dut (.I_SYS_CLK(clk), .I_RST(rst), .I_SERIAL_CLOCK(sclk), .I_CHIP_SELECT_N(cs_n),
        .I_DIN(din), .I_TOUCH_DETECT(touch), .O_TOUCH_IRQ_N(irq_n), .O_Y_MINUS_PLATE_GND_EN(gnd_en),
        .O_INTERNAL_PULLUP_EN(pu_en), .O_PLATE_DRIVE_EN(drv_en), .O_REF_POWER(ref_pw),
        .O_ADC_POWER(adc_pw), .O_FULL_POWER_DOWN(fpd), .O_CONFIGURED(cfg), .O_CTL_REG(ctl));

    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic settle();
        repeat (12) @(posedge clk);
        #1;
    endtask

    task automatic expect_val(input logic [1:0] sel, input logic [7:0] v);
        expq.push_back({sel, v});
    endtask

    // takes the oldest note and compares it with the output now
    initial begin
        logic [9:0] e;
        logic [7:0] seen;
        forever begin
            wait (expq.size() != 0);
            e = expq.pop_front();
            case (e[9:8])
                2'h0: seen = {7'h00, irq_n};
                2'h1: seen = ctl;
                2'h2: seen = {7'h00, ref_pw};
                default: seen = {7'h00, gnd_en};
            endcase
            num_checks++;
            if (seen !== e[7:0]) begin
                failures++;
                $display("Error %s expected %h seen %h", names[e[9:8]], e[7:0], seen);
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            final_report();
        end
    end

    task automatic do_reset();
        rst = 1'b1;
        host.pulses(4, 0);
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        // link reset is released only by serial clocks after the system reset
        host.pulses(3, 0);
        st = `PTIC_CTL_POWERUP;
        touch = 1'b1;
        settle();
        expect_val(2'h1, st);
        expect_val(2'h2, 8'h01);
        expect_val(2'h0, 8'h01);
        $display("reset test done");
    endtask

    task automatic frame(input logic [7:0] cmd, input int lead, input int gap);
        logic pl, opl;
        pl = MASK[cmd[6:4]];
        opl = MASK[st[6:4]];
        touch = $random(seed);
        host.start({cmd, 24'h0} >> lead);
        settle();
        expect_val(2'h0, {7'h00, st[0] ? ~opl : ~touch});
        host.pulses(lead + 7, gap);
        touch = $random(seed);
        settle();
        expect_val(2'h1, {st[7:2], cmd[1], st[0]});
        expect_val(2'h2, {7'h00, cmd[1]});
        expect_val(2'h0, {7'h00, ~pl});
        host.pulses(1, gap);
        settle();
        st = cmd;
        expect_val(2'h1, st);
        host.pulses(12, gap);
        touch = $random(seed);
        settle();
        expect_val(2'h0, {7'h00, cmd[0] ? ~pl : ~touch});
        host.pulses(4, gap);
        host.stop();
        touch = $random(seed);
        settle();
        expect_val(2'h0, {7'h00, (&cmd[1:0]) | ~touch});
        if (!(&cmd[1:0]))
            expect_val(2'h3, 8'h01);
    endtask

    initial begin
        rst = 1'b1;
        touch = 1'b0;
        st = 8'h00;
        do_reset();
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            frame({1'b1, i[2:0], r[1:0], r[2], i[3]}, (i == 5) ? 2 : 0, i[0] ? 0 : r[7:4]);
            $display("frame test %0d done", i);
        end
        host.hold_din(1'b1);
        touch = 1'b1;
        settle();
        st = `PTIC_CTL_CLEAR;
        expect_val(2'h1, st);
        expect_val(2'h0, 8'h01);
        host.hold_din(1'b0);
        settle();
        expect_val(2'h0, 8'h00);
        expect_val(2'h3, 8'h01);
        $display("full power-down test done");
        r = $random(seed);
        frame({1'b1, r[6:0]}, 0, 3);
        $display("frame after power-down done");
        do_reset();
        final_report();
    end
endmodule

bind ptic_top ptic_chk chk (.I_SYS_CLK, .I_RST, .I_SERIAL_CLOCK, .I_CHIP_SELECT_N, .I_DIN,
    .I_TOUCH_DETECT, .O_TOUCH_IRQ_N, .O_Y_MINUS_PLATE_GND_EN, .O_INTERNAL_PULLUP_EN,
    .O_PLATE_DRIVE_EN, .O_REF_POWER, .O_ADC_POWER, .O_FULL_POWER_DOWN, .O_CONFIGURED, .O_CTL_REG);

`default_nettype wire
